//--- pad_bank_pkg.sv
// shared constants for the configurable pad bank
// assumes a single 50 MHz system clock and synchronous reset
package pad_bank_pkg;
  localparam int unsigned num_pads = 8;
  localparam int unsigned num_fc_out = 4;
  localparam int unsigned num_fc_in = 2;
  // pad role encoding, two bits per pad
  localparam logic [1:0] role_input = 2'h0;
  localparam logic [1:0] role_output = 2'h1;
  localparam logic [1:0] role_alt = 2'h2;
  // reset values
  localparam logic [7:0] rst_role_bits = 8'h00;
  localparam logic [7:0] rst_out_value = 8'h00;
  localparam logic [7:0] rst_pull_up = 8'h00;
  localparam logic [3:0] rst_fc_value = 4'h0;
  localparam logic [3:0] rst_fc_gpo_sel = 4'h0;
  // flow-control output bit positions
  localparam int unsigned fc_dcd_bit = 0;
  localparam int unsigned fc_ring_bit = 1;
  localparam int unsigned fc_dsr_bit = 2;
  localparam int unsigned fc_cts_bit = 3;
  // flow-control input bit positions
  localparam int unsigned fc_dtr_bit = 0;
  localparam int unsigned fc_rts_bit = 1;
endpackage

//--- pad_sync.sv
// two-flop synchroniser for a bus of pad inputs
// assumes the bus bits are independent levels
module pad_sync #(
  parameter int unsigned width = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [width-1:0] async_i,
  output logic [width-1:0] sync_o
);
  logic [width-1:0] stage1;
  logic [width-1:0] stage2;
  logic [width-1:0] next_stage1;
  logic [width-1:0] next_stage2;

  // stage1 feeds only stage2, never other logic
  always_comb begin
    next_stage1 = async_i;
    next_stage2 = stage1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign sync_o = stage2;
endmodule

//--- pad_bank.sv
// configurable general purpose pad bank with flow-control pad reuse
// assumes pad inputs may be asynchronous; config bits come from firmware ports
//
// Contract
// (R01) each pad: input, output or alternate
// (R02) input pads read the sampled pad level
// (R03) output pads drive stored value, read it
// (R04) alternate role follows internal function
// (R05) reset: all inputs, pads show zero
// (R06) per-pad software pull-up or pull-down
// (R07) four flow outputs, two inputs reusable
// (R08) auxiliary port has only rx, tx
// (R09) aux serial and spi share pins
// (R10) outside logic tolerates power-up glitches
// (R11) inputs synchronised through two flops; shared pins a and b reach aux_rx_o, spi_mosi_o unsynchronised
module pad_bank (
  input wire logic clk_i,
  input wire logic rst_i,
  // software configuration, one write strobe
  input wire logic cfg_we_i,
  input wire logic [2*pad_bank_pkg::num_pads-1:0] cfg_role_i,
  input wire logic [pad_bank_pkg::num_pads-1:0] cfg_out_value_i,
  input wire logic [pad_bank_pkg::num_pads-1:0] cfg_pull_up_i,
  input wire logic [pad_bank_pkg::num_fc_out-1:0] cfg_fc_gpo_sel_i,
  input wire logic [pad_bank_pkg::num_fc_out-1:0] cfg_fc_value_i,
  input wire logic cfg_fc_gpi_sel_i,
  input wire logic spi_select_i,
  output logic [pad_bank_pkg::num_pads-1:0] read_value_o,
  output logic [2*pad_bank_pkg::num_pads-1:0] role_o,
  // alternate function side
  input wire logic [pad_bank_pkg::num_pads-1:0] alt_out_i,
  input wire logic [pad_bank_pkg::num_pads-1:0] alt_oe_i,
  input wire logic [pad_bank_pkg::num_fc_out-1:0] fc_handshake_i,
  output logic terminal_ready_o,
  output logic request_to_send_o,
  output logic [pad_bank_pkg::num_fc_in-1:0] fc_gpi_value_o,
  // configurable pads
  input wire logic [pad_bank_pkg::num_pads-1:0] pad_in_i,
  output logic [pad_bank_pkg::num_pads-1:0] pad_out_o,
  output logic [pad_bank_pkg::num_pads-1:0] pad_oe_o,
  output logic [pad_bank_pkg::num_pads-1:0] pad_pull_up_o,
  output logic [pad_bank_pkg::num_pads-1:0] pad_pull_down_o,
  // fixed-direction flow-control pads
  output logic carrier_detect_out_pad_o,
  output logic ring_out_pad_o,
  output logic set_ready_out_pad_o,
  output logic clear_to_send_out_pad_o,
  input wire logic terminal_ready_in_pad_i,
  input wire logic request_to_send_in_pad_i,
  // shared aux serial / spi data pins
  input wire logic aux_tx_i,
  output logic aux_rx_o,
  input wire logic spi_miso_i,
  output logic spi_mosi_o,
  input wire logic shared_pin_a_i,
  output logic shared_pin_a_o,
  output logic shared_pin_a_oe_o,
  input wire logic shared_pin_b_i,
  output logic shared_pin_b_o,
  output logic shared_pin_b_oe_o
);
  import pad_bank_pkg::*;

  // ************************************************************
  // configuration state
  // ************************************************************
  logic [2*num_pads-1:0] role;
  logic [num_pads-1:0] out_value;
  logic [num_pads-1:0] pull_up;
  logic [num_fc_out-1:0] fc_gpo_sel;
  logic [num_fc_out-1:0] fc_value;
  logic fc_gpi_sel;
  logic [2*num_pads-1:0] next_role;
  logic [num_pads-1:0] next_out_value;
  logic [num_pads-1:0] next_pull_up;
  logic [num_fc_out-1:0] next_fc_gpo_sel;
  logic [num_fc_out-1:0] next_fc_value;
  logic next_fc_gpi_sel;

  // reserved role code 3 folds into input so a pad has one role
  always_comb begin
    next_role = role;
    next_out_value = out_value;
    next_pull_up = pull_up;
    next_fc_gpo_sel = fc_gpo_sel;
    next_fc_value = fc_value;
    next_fc_gpi_sel = fc_gpi_sel;
    if (cfg_we_i) begin
      for (int i = 0; i < num_pads; i++) begin
        next_role[2*i +: 2] = (cfg_role_i[2*i +: 2] == 2'h3) ? role_input : cfg_role_i[2*i +: 2]; // R01
      end
      next_out_value = cfg_out_value_i; // R03
      next_pull_up = cfg_pull_up_i; // R06
      next_fc_gpo_sel = cfg_fc_gpo_sel_i; // R07
      next_fc_value = cfg_fc_value_i;
      next_fc_gpi_sel = cfg_fc_gpi_sel_i;
    end
  end

  // every pad returns to input role at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      role <= {num_pads{role_input}}; // R05
      out_value <= rst_out_value;
      pull_up <= rst_pull_up;
      fc_gpo_sel <= rst_fc_gpo_sel;
      fc_value <= rst_fc_value;
      fc_gpi_sel <= 1'b0;
    end else begin
      role <= next_role;
      out_value <= next_out_value;
      pull_up <= next_pull_up;
      fc_gpo_sel <= next_fc_gpo_sel;
      fc_value <= next_fc_value;
      fc_gpi_sel <= next_fc_gpi_sel;
    end
  end

  // ************************************************************
  // input synchronisation
  // ************************************************************
  logic [num_pads+num_fc_in-1:0] sync_in;

  pad_sync #(.width(num_pads + num_fc_in)) u_sync ( // R11
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({request_to_send_in_pad_i, terminal_ready_in_pad_i, pad_in_i}),
    .sync_o(sync_in)
  );

  // ************************************************************
  // per-pad drive and readback
  // ************************************************************
  logic [num_pads-1:0] next_read_value;
  logic [num_pads-1:0] read_value;

  // outputs: output role drives the stored bit, alternate follows the internal function
  generate
    for (genvar g = 0; g < num_pads; g++) begin : g_pad
      logic [1:0] r;
      assign r = role[2*g +: 2];
      assign pad_out_o[g] = rst_i ? 1'b0 : (r == role_alt) ? alt_out_i[g] : // R05 R04
                            (r == role_output) ? out_value[g] : 1'b0; // R03
      assign pad_oe_o[g] = !rst_i && ((r == role_output) || (r == role_alt && alt_oe_i[g])); // R01
      assign pad_pull_up_o[g] = pull_up[g]; // R06
      assign pad_pull_down_o[g] = !pull_up[g];
      assign next_read_value[g] = (r == role_output) ? out_value[g] : sync_in[g]; // R02 R03
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_value <= '0;
    end else begin
      read_value <= next_read_value;
    end
  end

  assign read_value_o = read_value;
  assign role_o = role;

  // ************************************************************
  // flow-control pads and shared aux / spi pins
  // ************************************************************
  logic [num_fc_out-1:0] fc_drive;
  logic [num_fc_out-1:0] next_fc_drive;
  logic [num_fc_in-1:0] fc_gpi;
  logic [num_fc_in-1:0] next_fc_gpi;

  // each flow output is either gpo value or its handshake line
  always_comb begin
    next_fc_drive = (fc_gpo_sel & fc_value) | (~fc_gpo_sel & fc_handshake_i); // R07
    next_fc_gpi = sync_in[num_pads +: num_fc_in];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fc_drive <= '0;
      fc_gpi <= '0;
    end else begin
      fc_drive <= next_fc_drive;
      fc_gpi <= next_fc_gpi;
    end
  end

  assign carrier_detect_out_pad_o = fc_drive[fc_dcd_bit];
  assign ring_out_pad_o = fc_drive[fc_ring_bit];
  assign set_ready_out_pad_o = fc_drive[fc_dsr_bit];
  assign clear_to_send_out_pad_o = fc_drive[fc_cts_bit];
  // handshake inputs are masked while reused as general inputs
  assign terminal_ready_o = fc_gpi_sel ? 1'b0 : fc_gpi[fc_dtr_bit]; // R07
  assign request_to_send_o = fc_gpi_sel ? 1'b0 : fc_gpi[fc_rts_bit];
  assign fc_gpi_value_o = fc_gpi;

  // pin a: aux receive or spi miso; pin b: aux transmit or spi mosi
  // only rx and tx exist, no modem control on the aux port
  assign aux_rx_o = spi_select_i ? 1'b1 : shared_pin_a_i; // R08 R09
  assign spi_mosi_o = spi_select_i ? shared_pin_b_i : 1'b0; // R09
  assign shared_pin_a_o = rst_i ? 1'b0 : (spi_select_i ? spi_miso_i : 1'b0);
  assign shared_pin_a_oe_o = !rst_i && spi_select_i;
  assign shared_pin_b_o = rst_i ? 1'b0 : (spi_select_i ? 1'b0 : aux_tx_i);
  assign shared_pin_b_oe_o = !rst_i && !spi_select_i;

  // ************************************************************
  // checks
  // ************************************************************
  chk_reset_input_role: assert property (@(posedge clk_i) rst_i |=> role == '0) // R05
    else $error("pad roles not input after reset");
  chk_reset_pad_low: assert property (@(posedge clk_i) rst_i |-> pad_out_o == '0 && pad_oe_o == '0) // R05
    else $error("pad not low during reset");
  chk_output_drives_store: assert property (@(posedge clk_i) disable iff (rst_i) // R03
    (role[1:0] == role_output) |-> pad_oe_o[0] && pad_out_o[0] == out_value[0])
    else $error("output pad not driving stored value");
  chk_alt_follows_fn: assert property (@(posedge clk_i) disable iff (rst_i) // R04
    (role[1:0] == role_alt) |-> pad_oe_o[0] == alt_oe_i[0] && pad_out_o[0] == alt_out_i[0])
    else $error("alternate pad not following function");
  // readback lags the pad by three edges; a reset in the last two flushes the synchroniser
  chk_input_readback: assert property (@(posedge clk_i) disable iff (rst_i) // R02 R11
    (role[1:0] == role_input) && !$past(rst_i, 1) && !$past(rst_i, 2)
    |=> read_value_o[0] == $past(pad_in_i[0], 3))
    else $error("input read not the sampled pad level");
  chk_input_no_drive: assert property (@(posedge clk_i) disable iff (rst_i) // R01
    (role[1:0] == role_input) |-> !pad_oe_o[0])
    else $error("input pad driving");
  chk_pull_select: assert property (@(posedge clk_i) disable iff (rst_i) // R06
    $past(cfg_we_i) && !$past(rst_i)
    |-> pad_pull_up_o == $past(cfg_pull_up_i) && pad_pull_down_o == ~$past(cfg_pull_up_i))
    else $error("pull selection not applied");
  chk_fc_gpo_value: assert property (@(posedge clk_i) disable iff (rst_i) // R07
    fc_gpo_sel[0] && $stable(fc_value) |=> carrier_detect_out_pad_o == $past(fc_value[0]))
    else $error("flow gpo not driving value");
  chk_shared_owner: assert property (@(posedge clk_i) disable iff (rst_i) // R09
    shared_pin_a_oe_o == spi_select_i && shared_pin_b_oe_o == !spi_select_i)
    else $error("shared pins owned by both ports");
  cov_output_role: cover property (@(posedge clk_i) role[1:0] == role_output ##1 pad_out_o[0]);
  cov_alt_role: cover property (@(posedge clk_i) role[1:0] == role_alt && alt_oe_i[0]);
  cov_spi_switch: cover property (@(posedge clk_i) !spi_select_i ##1 spi_select_i);
endmodule

//--- pad_partner.sv
// external hardware model on one group of pad wires
// assumes device and host never drive one wire together
module pad_partner #(
  parameter int unsigned width = 8
) (
  input wire logic [width-1:0] dev_out_i,
  input wire logic [width-1:0] dev_oe_i,
  input wire logic [width-1:0] pull_up_i,
  input wire logic [width-1:0] ext_oe_i,
  input wire logic [width-1:0] ext_val_i,
  output logic [width-1:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // wire level: device drive, else host drive, else the pull resistor
  // host samples only settled levels, power-up glitches ignored
  always_comb begin
    level_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & ext_oe_i & ext_val_i)
      | (~dev_oe_i & ~ext_oe_i & pull_up_i);
  end
endmodule

//--- configurable_io_pad_bank_bench.sv
// self-checking bench for the pad bank
// assumes the pad bank design and its package are compiled first
module configurable_io_pad_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pad_bank_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cfg_we_i = 1'b0, cfg_fc_gpi_sel_i = 1'b0, spi_select_i = 1'b0;
  logic [15:0] cfg_role_i = 16'h0000, role_o;
  logic [7:0] cfg_out_value_i = 8'h00, cfg_pull_up_i = 8'h00, alt_out_i = 8'hff, alt_oe_i = 8'hff;
  logic [7:0] read_value_o, pad_in_i, pad_out_o, pad_oe_o, pad_pull_up_o, pad_pull_down_o, ext_val = 8'hc4;
  logic [3:0] cfg_fc_gpo_sel_i = 4'h0, cfg_fc_value_i = 4'h0, fc_handshake_i = 4'h8;
  wire [3:0] fc_pads;
  logic [1:0] fc_gpi_value_o;
  logic terminal_ready_o, request_to_send_o, tr_in = 1'b1, rts_in = 1'b0;
  logic aux_tx_i = 1'b1, aux_rx_o, spi_miso_i = 1'b1, spi_mosi_o, ext_a = 1'b0, ext_b = 1'b1;
  logic pin_a, pin_a_o, pin_a_oe, pin_b, pin_b_o, pin_b_oe;
  int error_cnt = 0, total_checks = 0;
  // ****************************************
  // design and pin-side partners
  // ****************************************
  pad_bank dut (.clk_i(clk_i), .rst_i(rst_i), .cfg_we_i(cfg_we_i), .cfg_role_i(cfg_role_i),
    .cfg_out_value_i(cfg_out_value_i), .cfg_pull_up_i(cfg_pull_up_i), .cfg_fc_gpo_sel_i(cfg_fc_gpo_sel_i),
    .cfg_fc_value_i(cfg_fc_value_i), .cfg_fc_gpi_sel_i(cfg_fc_gpi_sel_i), .spi_select_i(spi_select_i),
    .read_value_o(read_value_o), .role_o(role_o), .alt_out_i(alt_out_i), .alt_oe_i(alt_oe_i),
    .fc_handshake_i(fc_handshake_i), .terminal_ready_o(terminal_ready_o),
    .request_to_send_o(request_to_send_o), .fc_gpi_value_o(fc_gpi_value_o), .pad_in_i(pad_in_i),
    .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pad_pull_up_o(pad_pull_up_o),
    .pad_pull_down_o(pad_pull_down_o), .carrier_detect_out_pad_o(fc_pads[0]), .ring_out_pad_o(fc_pads[1]),
    .set_ready_out_pad_o(fc_pads[2]), .clear_to_send_out_pad_o(fc_pads[3]),
    .terminal_ready_in_pad_i(tr_in), .request_to_send_in_pad_i(rts_in), .aux_tx_i(aux_tx_i),
    .aux_rx_o(aux_rx_o), .spi_miso_i(spi_miso_i), .spi_mosi_o(spi_mosi_o), .shared_pin_a_i(pin_a),
    .shared_pin_a_o(pin_a_o), .shared_pin_a_oe_o(pin_a_oe), .shared_pin_b_i(pin_b),
    .shared_pin_b_o(pin_b_o), .shared_pin_b_oe_o(pin_b_oe));
  pad_partner #(.width(8)) gpio_side (.dev_out_i(pad_out_o), .dev_oe_i(pad_oe_o),
    .pull_up_i(pad_pull_up_o), .ext_oe_i(~pad_oe_o), .ext_val_i(ext_val), .level_o(pad_in_i));
  // host drives rx when the aux port owns pin a, mosi when spi owns pin b
  pad_partner #(.width(1)) pin_a_side (.dev_out_i(pin_a_o), .dev_oe_i(pin_a_oe), .pull_up_i(1'b0),
    .ext_oe_i(~spi_select_i), .ext_val_i(ext_a), .level_o(pin_a));
  pad_partner #(.width(1)) pin_b_side (.dev_out_i(pin_b_o), .dev_oe_i(pin_b_oe), .pull_up_i(1'b0),
    .ext_oe_i(spi_select_i), .ext_val_i(ext_b), .level_o(pin_b));
  // ****************************************
  // clock, helpers
  // ****************************************
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // inputs move 1 ns after the edge to stay clear of sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // one-cycle config strobe, then settle past the synchronisers
  task automatic cfg_write();
    step(1);
    cfg_we_i = 1'b1;
    step(1);
    cfg_we_i = 1'b0;
    step(3);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    step(2);
    check({pad_out_o, pad_oe_o}, 16'h0000);
    step(3);
    rst_i = 1'b0;
    alt_out_i = 8'h10;
    alt_oe_i = 8'h30;
    step(1);
    check(role_o, 16'h0000);
    check({pad_pull_up_o, pad_pull_down_o}, 16'h00ff);
    // outputs, inputs, alternates and the unused code 3
    cfg_role_i = 16'h3a05;
    cfg_out_value_i = 8'h02;
    cfg_pull_up_i = 8'ha5;
    cfg_fc_gpo_sel_i = 4'h5;
    cfg_fc_value_i = 4'hf;
    cfg_write();
    check(role_o, 16'h0a05);
    check(pad_oe_o, 16'h0033);
    check(pad_out_o & pad_oe_o, 16'h0012);
    check({pad_pull_up_o, pad_pull_down_o}, 16'ha55a);
    check(read_value_o, 16'h00d6);
    check(fc_pads, 16'h000d);
    check({fc_gpi_value_o, terminal_ready_o, request_to_send_o}, 16'h0006);
    // a new pad level shows only after the two-flop delay and the readback register
    ext_val = 8'h08;
    step(1);
    check(read_value_o, 16'h00d6);
    step(2);
    check(read_value_o, 16'h001a);
    // pad 0 moves to alternate, flow inputs become general inputs
    cfg_role_i = 16'h3a06;
    cfg_fc_gpi_sel_i = 1'b1;
    cfg_write();
    check({fc_gpi_value_o, terminal_ready_o, request_to_send_o}, 16'h0004);
    check(role_o, 16'h0a06);
    alt_out_i = 8'h11;
    alt_oe_i = 8'h31;
    step(1);
    check({pad_oe_o, pad_out_o & pad_oe_o}, 16'h3313);
    // shared pins: aux port then spi
    check({pin_a_oe, pin_b_oe, pin_b_o, aux_rx_o}, 16'h0006);
    spi_select_i = 1'b1;
    step(1);
    check({pin_a_oe, pin_b_oe, pin_a_o, spi_mosi_o, aux_rx_o}, 16'h0017);
    // mid-run reset returns every pad to a quiet input
    rst_i = 1'b1;
    step(1);
    check({pad_oe_o, pin_a_oe, pin_b_oe}, 16'h0000);
    check(role_o, 16'h0000);
    summarize();
  end
endmodule
